// File: rtl/can_id_arbiter.sv
/*
 Shifts a standard identifier onto the bus, most significant bit first, and
 watches the bus level for lost arbitration.
 Assumes i_bus_bit is already synchronised and i_bit_tick marks sample points.
*/
`timescale 1ns/1ps
`include "can_id_map.svh"

module can_id_arbiter (
    // Clock and reset
    input  wire logic                     i_core_clk,
    input  wire logic                     i_rst,
    input  wire logic                     i_clk_en,
    // Control
    input  wire logic                     i_start,
    input  wire logic                     i_bit_tick,
    input  wire logic [`CAN_STD_ID_W-1:0] i_id,
    input  wire logic                     i_bus_bit,
    // Status
    output      logic                     o_tx_bit,
    output      logic                     o_busy,
    output      logic                     o_lost,
    output      logic                     o_won
);
    import can_id_pkg::*;

    arb_state_t               state;
    logic [`CAN_STD_ID_W-1:0] shadow;
    logic [`CAN_ARB_CNT_W-1:0] cnt;
    logic                     lose_now;

    // Recessive sent but dominant seen means a smaller identifier is on the bus
    assign lose_now = (o_tx_bit == `CAN_RECESSIVE) && (i_bus_bit == `CAN_DOMINANT);
    assign o_busy   = (state == ARB_SHIFT);

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            state    <= ARB_IDLE;
            shadow   <= '0;
            cnt      <= '0;
            o_tx_bit <= `CAN_RECESSIVE;
            o_lost   <= 1'b0;
            o_won    <= 1'b0;
        end else if (i_clk_en) begin
            o_lost <= 1'b0;
            o_won  <= 1'b0;
            case (state)
                ARB_IDLE: begin
                    o_tx_bit <= `CAN_RECESSIVE;
                    if (i_start) begin
                        shadow   <= i_id;
                        cnt      <= `CAN_ARB_LAST_BIT;
                        o_tx_bit <= i_id[`CAN_STD_ID_W-1];
                        state    <= ARB_SHIFT;
                    end
                end
                ARB_SHIFT: begin
                    if (i_bit_tick) begin
                        if (lose_now) begin
                            o_lost   <= 1'b1;
                            o_tx_bit <= `CAN_RECESSIVE;
                            state    <= ARB_IDLE;
                        end else if (cnt == '0) begin
                            o_won    <= 1'b1;
                            o_tx_bit <= `CAN_RECESSIVE;
                            state    <= ARB_IDLE;
                        end else begin
                            cnt      <= cnt - 1'b1;
                            o_tx_bit <= shadow[cnt - 1'b1];
                        end
                    end
                end
                default: state <= ARB_IDLE;
            endcase
        end
    end
endmodule

// File: rtl/can_id_buffer.sv
/*
 Standard identifier registers of one CAN message buffer, shared by software
 and the protocol engine, with identifier arbitration toward the bus pin.
 Assumes a single 25 MHz clock, a synchronous reset and an engine that pulses
 i_rx_store once per accepted frame.
*/
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "can_id_map.svh"

module can_id_buffer (
    // Clock and reset
    input  wire logic                     i_core_clk,
    input  wire logic                     i_rst,
    input  wire logic                     i_clk_en,
    // Register port
    input  wire can_id_pkg::reg_req_t     i_req,
    output      logic [7:0]               o_rdata,
    // Receive side of the protocol engine
    input  wire logic                     i_rx_store,
    input  wire can_id_pkg::std_frame_t   i_rx_frame,
    // Transmit side of the protocol engine
    output      can_id_pkg::std_frame_t   o_tx_frame,
    input  wire logic [`CAN_STD_ID_W-1:0] i_rival_id,
    output      logic                     o_outranks,
    // Arbitration toward the bus
    input  wire logic                     i_arb_start,
    input  wire logic                     i_bit_tick,
    input  wire logic                     i_can_rx,
    output      logic                     o_can_tx,
    output      logic                     o_arb_busy,
    output      logic                     o_arb_lost,
    output      logic                     o_arb_won
);
    import can_id_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Storage

    logic [7:0]               ident_high_std;
    logic [7:0]               ident_low_flags_std;
    logic [7:0]               ident_third_unused_std;
    logic [7:0]               ident_fourth_unused_std;
    logic [`CAN_STD_ID_W-1:0] own_id;
    logic                     next_rtr;
    logic                     outranks_c;
    logic                     rx_ff1;
    logic                     rx_ff2;
    logic                     rx_ff3;
    logic                     bus_bit;

    // Engine store wins over a software write in the same cycle
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            ident_high_std <= `CAN_REG_RESET;
        end else if (i_clk_en) begin
            if (i_rx_store) begin
                ident_high_std <= i_rx_frame.id[`CAN_ID_HIGH_MSB:`CAN_ID_HIGH_LSB];
            end else if (i_req.wr && i_req.addr == `CAN_OFF_IDENT_HIGH) begin
                ident_high_std <= i_req.wdata;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            ident_low_flags_std <= `CAN_REG_RESET;
        end else if (i_clk_en) begin
            if (i_rx_store) begin
                ident_low_flags_std[`CAN_LOW_ID_HI_BIT:`CAN_LOW_ID_LO_BIT]
                    <= i_rx_frame.id[`CAN_ID_LOW_MSB:0];
                ident_low_flags_std[`CAN_IDE_BIT] <= i_rx_frame.ide;
                if (!i_rx_frame.ide) begin
                    ident_low_flags_std[`CAN_STD_RTR_BIT] <= i_rx_frame.rtr;
                end
            end else if (i_req.wr && i_req.addr == `CAN_OFF_IDENT_LOW) begin
                // Low bits are kept as written; they carry no meaning here
                ident_low_flags_std <= i_req.wdata;
            end
        end
    end

    // Third and fourth bytes behave as plain RAM in standard mapping
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            ident_third_unused_std <= `CAN_REG_RESET;
        end else if (i_clk_en && i_req.wr && i_req.addr == `CAN_OFF_IDENT_THIRD) begin
            ident_third_unused_std <= i_req.wdata;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            ident_fourth_unused_std <= `CAN_REG_RESET;
        end else if (i_clk_en) begin
            if (i_rx_store && i_rx_frame.ide) begin
                ident_fourth_unused_std[`CAN_EXT_RTR_BIT] <= i_rx_frame.rtr;
            end else if (i_req.wr && i_req.addr == `CAN_OFF_IDENT_FOURTH) begin
                ident_fourth_unused_std <= i_req.wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register read

    // Unmapped offsets read zero so software never sees stale data
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_rdata <= `CAN_RDATA_IDLE;
        end else if (i_clk_en) begin
            o_rdata <= `CAN_RDATA_IDLE;
            if (i_req.rd) begin
                case (i_req.addr)
                    `CAN_OFF_IDENT_HIGH:   o_rdata <= ident_high_std;
                    `CAN_OFF_IDENT_LOW:    o_rdata <= ident_low_flags_std;
                    `CAN_OFF_IDENT_THIRD:  o_rdata <= ident_third_unused_std;
                    `CAN_OFF_IDENT_FOURTH: o_rdata <= ident_fourth_unused_std;
                    default:               o_rdata <= `CAN_RDATA_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit view

    assign own_id = join_id(ident_high_std, ident_low_flags_std);

    // Extended mapping moves the remote bit to the fourth byte
    always_comb begin
        next_rtr = ident_low_flags_std[`CAN_STD_RTR_BIT];
        if (ident_low_flags_std[`CAN_IDE_BIT]) begin
            next_rtr = ident_fourth_unused_std[`CAN_EXT_RTR_BIT];
        end
    end

    // Only the thirteen meaningful bits reach the engine
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_tx_frame <= '0;
        end else if (i_clk_en) begin
            o_tx_frame.id  <= own_id;
            o_tx_frame.rtr <= next_rtr;
            o_tx_frame.ide <= ident_low_flags_std[`CAN_IDE_BIT];
        end
    end

    can_id_priority u_priority (
        .i_own_id   (own_id),
        .i_rival_id (i_rival_id),
        .o_outranks (outranks_c)
    );

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_outranks <= 1'b0;
        end else if (i_clk_en) begin
            o_outranks <= outranks_c;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus pin and arbitration

    // Three stages; the level moves only when the last two agree
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            rx_ff1  <= `CAN_RECESSIVE;
            rx_ff2  <= `CAN_RECESSIVE;
            rx_ff3  <= `CAN_RECESSIVE;
            bus_bit <= `CAN_RECESSIVE;
        end else if (i_clk_en) begin
            rx_ff1 <= i_can_rx;
            rx_ff2 <= rx_ff1;
            rx_ff3 <= rx_ff2;
            if (rx_ff2 == rx_ff3) begin
                bus_bit <= rx_ff3;
            end
        end
    end

    can_id_arbiter u_arbiter (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_clk_en   (i_clk_en),
        .i_start    (i_arb_start),
        .i_bit_tick (i_bit_tick),
        .i_id       (own_id),
        .i_bus_bit  (bus_bit),
        .o_tx_bit   (o_can_tx),
        .o_busy     (o_arb_busy),
        .o_lost     (o_arb_lost),
        .o_won      (o_arb_won)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    property p_rx_high;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_clk_en && i_rx_store) |=> (ident_high_std == $past(i_rx_frame.id[10:3]));
    endproperty
    a_rx_high: assert property (p_rx_high) else $error("high id byte wrong");

    property p_rx_low;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_clk_en && i_rx_store) |=> (ident_low_flags_std[7:5] == $past(i_rx_frame.id[2:0]));
    endproperty
    a_rx_low: assert property (p_rx_low) else $error("low id bits wrong");

    property p_rx_rtr;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_clk_en && i_rx_store && !i_rx_frame.ide)
            |=> (ident_low_flags_std[4] == $past(i_rx_frame.rtr));
    endproperty
    a_rx_rtr: assert property (p_rx_rtr) else $error("received remote bit lost");

    property p_rx_ide;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_clk_en && i_rx_store) |=> (ident_low_flags_std[3] == $past(i_rx_frame.ide));
    endproperty
    a_rx_ide: assert property (p_rx_ide) else $error("received format flag lost");

    property p_tx_rtr;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_clk_en && !ident_low_flags_std[3])
            |=> (o_tx_frame.rtr == $past(ident_low_flags_std[4]));
    endproperty
    a_tx_rtr: assert property (p_tx_rtr) else $error("sent remote bit wrong");

    property p_tx_ext_rtr;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_clk_en && ident_low_flags_std[3])
            |=> (o_tx_frame.rtr == $past(ident_fourth_unused_std[0]));
    endproperty
    a_tx_ext_rtr: assert property (p_tx_ext_rtr) else $error("extended remote bit wrong");

    property p_tx_ide;
        @(posedge i_core_clk) disable iff (i_rst)
        i_clk_en |=> (o_tx_frame.ide == $past(ident_low_flags_std[3]));
    endproperty
    a_tx_ide: assert property (p_tx_ide) else $error("sent format flag wrong");

    property p_tx_ignore;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_clk_en && $changed(ident_third_unused_std) && $stable(ident_high_std)
            && $stable(ident_low_flags_std[7:5])) |=> $stable(o_tx_frame.id);
    endproperty
    a_tx_ignore: assert property (p_tx_ignore) else $error("unused byte reached id");

    property p_msb_first;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_clk_en && i_arb_start && !o_arb_busy) |=> (o_can_tx == $past(own_id[10]));
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("first bit not id msb");

    property p_priority;
        @(posedge i_core_clk) disable iff (i_rst)
        i_clk_en |=> (o_outranks == ($past(own_id) < $past(i_rival_id)));
    endproperty
    a_priority: assert property (p_priority) else $error("priority compare wrong");

    property p_read_third;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_clk_en && i_req.rd && i_req.addr == 4'h2 && !i_req.wr)
            |=> (o_rdata == $past(ident_third_unused_std));
    endproperty
    a_read_third: assert property (p_read_third) else $error("third byte read wrong");

    property p_field_width;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_clk_en && !ident_low_flags_std[3])
            |=> (o_tx_frame == {$past(ident_high_std), $past(ident_low_flags_std[7:3])});
    endproperty
    a_field_width: assert property (p_field_width) else $error("standard field wrong");

    // Idle read data is zero so a stale byte never looks like an answer
    property p_read_idle;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_clk_en && !i_req.rd) |=> (o_rdata == `CAN_RDATA_IDLE);
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("read data not idle");

    property p_arb_lost;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_clk_en && o_arb_busy && i_bit_tick && o_can_tx && !bus_bit) |=> o_arb_lost;
    endproperty
    a_arb_lost: assert property (p_arb_lost) else $error("lost arbitration missed");

endmodule

// File: rtl/can_id_map.svh
/*
 Offsets, field positions, reset values and widths of the standard identifier
 registers of one message buffer.
 Assumes it is included once per file that needs it, by its bare name.
*/
`ifndef CAN_ID_MAP_SVH
`define CAN_ID_MAP_SVH

// Register port
`define CAN_ADDR_W          4
`define CAN_OFF_IDENT_HIGH  4'h0
`define CAN_OFF_IDENT_LOW   4'h1
`define CAN_OFF_IDENT_THIRD 4'h2
`define CAN_OFF_IDENT_FOURTH 4'h3
`define CAN_REG_RESET       8'h00
`define CAN_RDATA_IDLE      8'h00

// Field layout
`define CAN_STD_ID_W        11
`define CAN_STD_FIELD_W     13
`define CAN_ID_HIGH_MSB     10
`define CAN_ID_HIGH_LSB     3
`define CAN_ID_LOW_MSB      2
`define CAN_LOW_ID_HI_BIT   7
`define CAN_LOW_ID_LO_BIT   5
`define CAN_STD_RTR_BIT     4
`define CAN_IDE_BIT         3
`define CAN_EXT_RTR_BIT     0

// Arbitration
`define CAN_ARB_CNT_W       4
`define CAN_ARB_LAST_BIT    4'ha
`define CAN_RECESSIVE       1'b1
`define CAN_DOMINANT        1'b0

`endif

// File: rtl/can_id_pkg.sv
/*
 Types shared by the identifier buffer and its helpers.
 Assumes can_id_map.svh supplies the widths.
*/
`include "can_id_map.svh"

package can_id_pkg;

    // Standard-format identifier field as the protocol engine sees it
    typedef struct packed {
        logic [`CAN_STD_ID_W-1:0] id;
        logic                     rtr;
        logic                     ide;
    } std_frame_t;

    // One register port request
    typedef struct packed {
        logic [`CAN_ADDR_W-1:0] addr;
        logic [7:0]             wdata;
        logic                   wr;
        logic                   rd;
    } reg_req_t;

    typedef enum logic {
        ARB_IDLE,
        ARB_SHIFT
    } arb_state_t;

    // Identifier rebuilt from the two standard registers
    function automatic logic [`CAN_STD_ID_W-1:0] join_id(input logic [7:0] high,
                                                          input logic [7:0] low);
        join_id = {high, low[`CAN_LOW_ID_HI_BIT:`CAN_LOW_ID_LO_BIT]};
    endfunction

endpackage

// File: rtl/can_id_priority.sv
/*
 Compares two standard identifiers for bus priority.
 Assumes both inputs are stable identifiers on the same clock.
*/
`timescale 1ns/1ps
`include "can_id_map.svh"

module can_id_priority (
    // Identifiers
    input  wire logic [`CAN_STD_ID_W-1:0] i_own_id,
    input  wire logic [`CAN_STD_ID_W-1:0] i_rival_id,
    // Result
    output      logic                     o_outranks
);
    import can_id_pkg::*;

    // Smaller value wins, as dominant zeros override on the wire
    assign o_outranks = (i_own_id < i_rival_id);
endmodule

// File: verification/can_bus_node.sv
/*
 Far-side model: one rival node on a wired-AND bus plus the bit sample ticks.
 Assumes the block's start pulse and the rival identifier come from the bench.
*/
`timescale 1ns/1ps

module can_bus_node (
    // Clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    // Arbitration
    input  wire logic        i_start,
    input  wire logic        i_tx,
    input  wire logic [10:0] i_rival_id,
    // Bus
    output      logic        o_bus,
    output      logic        o_tick
);
    logic       active;
    logic [3:0] idx;
    logic [2:0] cnt;
    logic       rival_bit;

    ////////////////////////////////////////////////////////////////////////////
    // Rival drives its identifier MSB first, then stays recessive
    assign rival_bit = active ? i_rival_id[idx] : 1'b1;
    // Dominant zero overrides recessive one
    assign o_bus     = i_tx & rival_bit;

    ////////////////////////////////////////////////////////////////////////////
    // Ticks restart at each start so the block's input sync has settled first
    always_ff @(posedge i_core_clk) begin
        if (i_rst || i_start) begin
            cnt    <= 3'h0;
            o_tick <= 1'b0;
        end else begin
            cnt    <= cnt + 3'h1;
            o_tick <= (cnt == 3'h6);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            active <= 1'b0;
            idx    <= 4'ha;
        end else if (i_start) begin
            active <= 1'b1;
            idx    <= 4'ha;
        end else if (active && o_tick) begin
            if ((rival_bit && !o_bus) || idx == 4'h0) begin
                active <= 1'b0;
            end else begin
                idx <= idx - 4'h1;
            end
        end
    end
endmodule

// File: verification/tb_top.sv
/*
 Self-checking bench for the standard identifier buffer.
 Assumes the bus node model and a 25 MHz clock; reads are checked from a queue.
*/
`timescale 1ns/1ps
`include "can_id_map.svh"

module tb_top;
    import can_id_pkg::*;
    logic        i_core_clk, i_rst, i_clk_en, i_rx_store, i_arb_start;
    reg_req_t    i_req;
    std_frame_t  i_rx_frame, o_tx_frame, f;
    logic [10:0] i_rival_id, id, rv;
    logic [7:0]  o_rdata, s1, s3, x;
    logic        bit_tick, can_rx, o_can_tx, o_outranks, o_arb_busy, o_arb_lost, o_arb_won;
    logic        rd_d;
    logic [7:0]  exp_q[$];
    logic [31:0] seed = 32'h54;
    int          failures, n_tests, n;

    can_id_buffer DUT (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_clk_en(i_clk_en),
        .i_req(i_req), .o_rdata(o_rdata), .i_rx_store(i_rx_store), .i_rx_frame(i_rx_frame),
        .o_tx_frame(o_tx_frame), .i_rival_id(i_rival_id), .o_outranks(o_outranks),
        .i_arb_start(i_arb_start), .i_bit_tick(bit_tick), .i_can_rx(can_rx),
        .o_can_tx(o_can_tx), .o_arb_busy(o_arb_busy), .o_arb_lost(o_arb_lost),
        .o_arb_won(o_arb_won));
    can_bus_node u_node (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_start(i_arb_start),
        .i_tx(o_can_tx), .i_rival_id(i_rival_id), .o_bus(can_rx), .o_tick(bit_tick));

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        i_req <= {a, d, 1'b1, 1'b0};
        @(posedge i_core_clk);
        i_req <= '0;
    endtask

    // Read data stand one cycle only, so the watcher compares at that cycle
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge i_core_clk);
        i_req <= {a, 8'h00, 1'b0, 1'b1};
        exp_q.push_back(e);
        @(posedge i_core_clk);
        i_req <= '0;
    endtask

    task automatic settle();
        repeat (3) @(posedge i_core_clk);
        @(negedge i_core_clk);
    endtask

    task automatic end_sim();
        if (failures == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        i_core_clk = 1'b0;
        forever #20 i_core_clk = ~i_core_clk;
    end

    always @(posedge i_core_clk) rd_d <= i_req.rd && i_clk_en;
    always @(negedge i_core_clk) begin
        if (rd_d) check("rdata", o_rdata, exp_q.pop_front());
        else check("rdata_idle", o_rdata, 8'h00);
    end

    initial begin
        #(40 * 20000);
        failures++;
        end_sim();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        i_rst = 1'b1;
        i_clk_en = 1'b1;
        i_rx_store = 1'b0;
        i_arb_start = 1'b0;
        i_req = '0;
        i_rx_frame = '0;
        i_rival_id = 11'h000;
        repeat (12) @(posedge i_core_clk);
        i_rst <= 1'b0;
        // Reset contents and an unmapped offset that ignores writes
        for (int a = 0; a < 4; a++) rd(a[3:0], 8'h00);
        wr(4'h9, 8'hff);
        rd(4'h9, 8'h00);
        // Software layout, transmit view and priority compare
        for (int i = 0; i < 8; i++) begin
            id = 11'(rnd());
            x = 8'(rnd());
            s1 = {id[2:0], x[7], 1'b0, x[2:0]};
            wr(`CAN_OFF_IDENT_HIGH, id[10:3]);
            wr(`CAN_OFF_IDENT_LOW, s1);
            wr(`CAN_OFF_IDENT_FOURTH, x);
            wr(`CAN_OFF_IDENT_THIRD, ~x);
            rd(`CAN_OFF_IDENT_HIGH, id[10:3]);
            rd(`CAN_OFF_IDENT_LOW, s1);
            rd(`CAN_OFF_IDENT_THIRD, ~x);
            i_rival_id <= 11'(rnd());
            settle();
            check("tx_frame", o_tx_frame, {id, x[7], 1'b0});
            check("outranks", o_outranks, id < i_rival_id);
            wr(`CAN_OFF_IDENT_LOW, s1 | 8'h08);
            settle();
            check("tx_frame_ext", o_tx_frame, {id, x[0], 1'b1});
        end
        // Engine stores received frames and beats a same-cycle software write
        s1 = s1 | 8'h08; s3 = x;
        for (int i = 0; i < 6; i++) begin
            f = 13'(rnd());
            @(posedge i_core_clk);
            i_rx_store <= 1'b1;
            i_rx_frame <= f;
            i_req <= {`CAN_OFF_IDENT_HIGH, ~f.id[10:3], 1'b1, 1'b0};
            @(posedge i_core_clk);
            i_rx_store <= 1'b0;
            i_req <= '0;
            s1 = {f.id[2:0], f.ide ? s1[4] : f.rtr, f.ide, s1[2:0]};
            if (f.ide) s3[0] = f.rtr;
            rd(`CAN_OFF_IDENT_HIGH, f.id[10:3]);
            rd(`CAN_OFF_IDENT_LOW, s1);
            rd(`CAN_OFF_IDENT_FOURTH, s3);
        end
        // A write with the clock enable low is not taken
        @(posedge i_core_clk);
        i_clk_en <= 1'b0;
        wr(`CAN_OFF_IDENT_HIGH, ~f.id[10:3]);
        i_clk_en <= 1'b1;
        rd(`CAN_OFF_IDENT_HIGH, f.id[10:3]);
        // Arbitration against the rival node, boundary identifiers first
        for (int i = 0; i < 6; i++) begin
            id = (i == 0) ? 11'h000 : (i == 1) ? 11'h7ff : 11'(rnd());
            rv = (i == 0) ? 11'h7ff : (i == 1) ? 11'h000 : 11'(rnd());
            if (rv == id) rv = ~id;
            wr(`CAN_OFF_IDENT_HIGH, id[10:3]);
            wr(`CAN_OFF_IDENT_LOW, {id[2:0], 5'h00});
            i_rival_id <= rv;
            settle();
            @(posedge i_core_clk);
            i_arb_start <= 1'b1;
            @(posedge i_core_clk);
            i_arb_start <= 1'b0;
            for (int k = 10; k >= 0; k--) begin
                n = 0;
                do @(negedge i_core_clk); while (!bit_tick && ++n < 40);
                check("tick_wait", n < 40, 1'b1);
                check("tx_bit", o_can_tx, id[k]);
                check("busy", o_arb_busy, 1'b1);
                // Only the first differing bit decides; once the block is beaten it stops sending its identifier
                if (id[k] && !rv[k] && (id >> (k + 1)) == (rv >> (k + 1))) break;
            end
            n = 0;
            do @(negedge i_core_clk); while (!(o_arb_won || o_arb_lost) && ++n < 20);
            check("result_wait", n < 20, 1'b1);
            check("won", o_arb_won, id < rv);
            check("lost", o_arb_lost, id > rv);
        end
        repeat (4) @(posedge i_core_clk);
        end_sim();
    end
endmodule
